// ===== adcc_top.sv
/*
  conversion and over-temperature control around a 10-bit successive
  approximation converter, with serial result read-out and APB registers.
  assumes an analog comparator and DAC outside, and a host driving the
  trigger, port select, read/write and serial clock pins.
*/
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module adcc_top
  import adcc_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // host pins
  input  wire logic        conversion_trigger_n,
  input  wire logic        port_select_n,
  input  wire logic        read_write_sel,
  input  wire logic        serial_clk,
  input  wire logic        serial_din,
  output logic             serial_dout,
  output logic             serial_dout_oe,
  output logic             busy,
  output logic             over_temp_flag_n,
  // analog front end
  input  wire logic        comparator_above,
  output logic      [9:0]  dac_code,
  output logic      [2:0]  channel_sel,
  output logic             hold_mode,
  output logic             power_down,
  // interrupt
  output logic             irq
);

  logic [SY_W-1:0] sy_level;
  logic [SY_W-1:0] sy_rise;
  logic [SY_W-1:0] sy_fall;

  adcc_sync #(
    .W (SY_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({comparator_above, serial_din, serial_clk,
                read_write_sel, port_select_n, conversion_trigger_n}),
    .level    (sy_level),
    .rise     (sy_rise),
    .fall     (sy_fall)
  );

  adcc_state_e       state_reg;
  logic [3:0]        bit_idx_reg;
  logic [8:0]        step_cnt_reg;
  logic [8:0]        step_len_reg;
  logic [9:0]        code_reg;
  logic [9:0]        result_reg;
  logic [2:0]        chan_reg;
  logic [2:0]        conv_chan_reg;
  logic [7:0]        thresh_reg;
  logic [IRQ_W-1:0]  irq_stat_reg;
  logic [IRQ_W-1:0]  irq_stat_next;
  logic [IRQ_W-1:0]  irq_mask_reg;
  logic [IRQ_W-1:0]  irq_snap_reg;
  logic [9:0]        tx_shift_reg;
  logic [7:0]        rx_shift_reg;
  logic [3:0]        rx_cnt_reg;
  logic [7:0]        ser_rx_reg;
  logic              busy_reg;
  logic              flag_n_reg;
  logic              hold_reg;
  logic              pdown_reg;
  logic              dout_reg;
  logic              dout_oe_reg;
  logic              irq_reg;
  logic [31:0]       prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;

  logic conv_start;
  logic step_end;
  logic conv_end;
  logic [9:0] final_code;
  logic cs_low;
  logic read_end;
  logic ovt_event;
  logic apb_setup;
  logic apb_done;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign conv_start = sy_fall[SY_TRIG] && (state_reg == ADCC_IDLE);
  assign step_end   = (state_reg == ADCC_CONV) && (step_cnt_reg == step_len_reg);
  assign conv_end   = step_end && (bit_idx_reg == 4'h0);
  assign final_code = sy_level[SY_CMP] ? code_reg : (code_reg & ~(10'h001 << bit_idx_reg));

  assign cs_low   = ~sy_level[SY_CS];
  assign read_end = sy_rise[SY_RDWR] && cs_low;
  assign ovt_event = conv_end && (conv_chan_reg == TEMP_CHAN) &&
                     (final_code[9:2] > thresh_reg);

  // conversion sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ADCC_IDLE;
    end else begin
      unique case (state_reg)
        ADCC_IDLE: begin
          if (conv_start) begin
            state_reg <= ADCC_CONV;
          end
        end
        ADCC_CONV: begin
          if (conv_end) begin
            state_reg <= ADCC_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_cnt_reg  <= 9'h000;
      step_len_reg  <= VOLT_STEP;
      bit_idx_reg   <= 4'h0;
      conv_chan_reg <= CHAN_RST;
    end else if (conv_start) begin
      step_cnt_reg  <= 9'h000;
      step_len_reg  <= (chan_reg == TEMP_CHAN) ? TEMP_STEP : VOLT_STEP;
      bit_idx_reg   <= MSB_IDX;
      conv_chan_reg <= chan_reg;
    end else if (step_end) begin
      step_cnt_reg <= 9'h000;
      bit_idx_reg  <= bit_idx_reg - 4'h1;
    end else if (state_reg == ADCC_CONV) begin
      step_cnt_reg <= step_cnt_reg + 9'h001;
    end
  end

  // successive approximation trial code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_reg   <= 10'h000;
      result_reg <= 10'h000;
    end else if (conv_start) begin
      code_reg <= MID_CODE;
    end else if (conv_end) begin
      code_reg   <= final_code;
      result_reg <= final_code;
    end else if (step_end) begin
      code_reg <= final_code | (10'h001 << (bit_idx_reg - 4'h1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else if (conv_start) begin
      busy_reg <= 1'b1;
    end else if (conv_end) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_reg <= 1'b0;
    end else if (conv_start) begin
      hold_reg <= 1'b1;
    end else if (conv_end) begin
      hold_reg <= 1'b0;
    end
  end

  // trigger level at end
  // a rising trigger edge wakes the converter for the next sample
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdown_reg <= 1'b0;
    end else if (conv_end) begin
      pdown_reg <= ~sy_level[SY_TRIG];
    end else if (sy_rise[SY_TRIG] || conv_start) begin
      pdown_reg <= 1'b0;
    end
  end

  // sticky flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_n_reg <= 1'b1;
    end else if (ovt_event) begin
      flag_n_reg <= 1'b0;
    end else if (read_end) begin
      flag_n_reg <= 1'b1;
    end
  end

  // output shifts on falling serial clock
  // float on read/write fall or select rise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_reg <= 10'h000;
      dout_reg     <= 1'b0;
      dout_oe_reg  <= 1'b0;
    end else if (sy_fall[SY_RDWR] || sy_rise[SY_CS]) begin
      dout_oe_reg <= 1'b0;
    end else if (read_end) begin
      tx_shift_reg <= {result_reg[8:0], 1'b0};
      dout_reg     <= result_reg[9];
      dout_oe_reg  <= 1'b1;
    end else if (sy_fall[SY_SCLK] && cs_low && dout_oe_reg) begin
      tx_shift_reg <= {tx_shift_reg[8:0], 1'b0};
      dout_reg     <= tx_shift_reg[9];
    end
  end

  // input captured on rising serial clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_reg <= 8'h00;
      rx_cnt_reg   <= 4'h0;
      ser_rx_reg   <= 8'h00;
    end else if (!cs_low || sy_level[SY_RDWR]) begin
      rx_cnt_reg <= 4'h0;
    end else if (sy_rise[SY_SCLK]) begin
      rx_shift_reg <= {rx_shift_reg[6:0], sy_level[SY_DIN]};
      if (rx_cnt_reg == RX_LAST) begin
        ser_rx_reg <= {rx_shift_reg[6:0], sy_level[SY_DIN]};
        rx_cnt_reg <= 4'h0;
      end else begin
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
    end
  end

  // apb: one wait state so read data leaves a flop
  assign apb_setup = psel && penable && !pready_reg;
  assign apb_done  = psel && penable && pready_reg;

  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFS:     rd_mux[2:0] = chan_reg;
      THRESH_OFS:   rd_mux[7:0] = thresh_reg;
      STATE_OFS: begin
        rd_mux[ST_BUSY]    = busy_reg;
        rd_mux[ST_FLAG_N]  = flag_n_reg;
        rd_mux[ST_PDOWN]   = pdown_reg;
        rd_mux[ST_HOLD]    = hold_reg;
        rd_mux[ST_DOUT_OE] = dout_oe_reg;
      end
      RESULT_OFS:   rd_mux[9:0] = result_reg;
      IRQ_STAT_OFS: rd_mux[IRQ_W-1:0] = irq_stat_reg;
      IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = irq_mask_reg;
      SER_RX_OFS:   rd_mux[7:0] = ser_rx_reg;
      default:      addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= apb_setup;
      if (apb_setup) begin
        prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= ~addr_ok;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // writable control; a channel change only applies to the next conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_reg     <= CHAN_RST;
      thresh_reg   <= THRESH_RST;
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (apb_done && pwrite) begin
      if (paddr == CTRL_OFS) begin
        chan_reg <= pwdata[2:0];
      end
      if (paddr == THRESH_OFS) begin
        thresh_reg <= pwdata[7:0];
      end
      if (paddr == IRQ_MASK_OFS) begin
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // read clears only the bits that were returned, so a new event survives
  always_comb begin
    irq_stat_next = irq_stat_reg;
    if (apb_done && !pwrite && (paddr == IRQ_STAT_OFS)) begin
      irq_stat_next = irq_stat_reg & ~irq_snap_reg;
    end
    irq_stat_next[IRQ_DONE]  = irq_stat_next[IRQ_DONE] | conv_end;
    irq_stat_next[IRQ_OVT]   = irq_stat_next[IRQ_OVT] | ovt_event;
    irq_stat_next[IRQ_RDEND] = irq_stat_next[IRQ_RDEND] | read_end;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= '0;
      irq_snap_reg <= '0;
      irq_reg      <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (apb_setup) begin
        irq_snap_reg <= irq_stat_reg;
      end
      irq_reg <= |(irq_stat_next & irq_mask_reg);
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign serial_dout      = dout_reg;
  assign serial_dout_oe   = dout_oe_reg;
  assign busy             = busy_reg;
  assign over_temp_flag_n = flag_n_reg;
  assign dac_code         = code_reg;
  assign channel_sel      = conv_chan_reg;
  assign hold_mode        = hold_reg;
  assign power_down       = pdown_reg;
  assign irq              = irq_reg;

endmodule

// ===== adcc_pkg.sv
/*
  constants for the converter control block: register map, field
  positions, reset values, conversion timing and state encoding.
  assumes a 10 MHz pclk and an APB master with 32-bit data.
*/
// Function
// - a falling trigger edge starts one 10-bit conversion
// - that same falling edge puts the sampling stage into hold
// - sampling stage returns to track when the conversion ends
// - trigger level low at conversion end enters power-down
// - busy is high for the whole conversion, low when it ends
// - channel 0 result above the 8-bit threshold drives the flag low
// - flag released on read/write rising edge while port select is low
// - serial port is ignored unless port select is low
// - data leaves on serial clock falling edges, enters on rising edges
// - serial output floats on read/write fall or port select rise
// - temperature conversion within 27 us, voltage within 9 us
package adcc_pkg;

  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TEMP_CONV_NS   = 27000;
  localparam int unsigned VOLT_CONV_NS   = 9000;
  localparam int unsigned RES_BITS       = 10;
  // longest times round down, so the per-bit step keeps within the limit
  localparam int unsigned TEMP_STEP_CYC  = TEMP_CONV_NS / CLK_PERIOD_NS / RES_BITS;
  localparam int unsigned VOLT_STEP_CYC  = VOLT_CONV_NS / CLK_PERIOD_NS / RES_BITS;
  localparam logic [8:0]  TEMP_STEP      = 9'(TEMP_STEP_CYC - 1);
  localparam logic [8:0]  VOLT_STEP      = 9'(VOLT_STEP_CYC - 1);
  localparam logic [3:0]  MSB_IDX        = 4'h9;
  localparam logic [9:0]  MID_CODE       = 10'h200;
  localparam logic [3:0]  RX_LAST        = 4'h7;

  // register byte offsets
  localparam logic [7:0]  CTRL_OFS       = 8'h00;
  localparam logic [7:0]  THRESH_OFS     = 8'h04;
  localparam logic [7:0]  STATE_OFS      = 8'h08;
  localparam logic [7:0]  RESULT_OFS     = 8'h0c;
  localparam logic [7:0]  IRQ_STAT_OFS   = 8'h10;
  localparam logic [7:0]  IRQ_MASK_OFS   = 8'h14;
  localparam logic [7:0]  SER_RX_OFS     = 8'h18;

  // reset values
  localparam logic [2:0]  CHAN_RST       = 3'h0;
  localparam logic [7:0]  THRESH_RST     = 8'hff;
  localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;
  localparam logic [2:0]  TEMP_CHAN      = 3'h0;

  // state register fields
  localparam int unsigned ST_BUSY        = 0;
  localparam int unsigned ST_FLAG_N      = 1;
  localparam int unsigned ST_PDOWN       = 2;
  localparam int unsigned ST_HOLD        = 3;
  localparam int unsigned ST_DOUT_OE     = 4;

  // interrupt status / mask fields
  localparam int unsigned IRQ_W          = 3;
  localparam int unsigned IRQ_DONE       = 0;
  localparam int unsigned IRQ_OVT        = 1;
  localparam int unsigned IRQ_RDEND      = 2;

  // synchroniser lanes
  localparam int unsigned SY_W           = 6;
  localparam int unsigned SY_TRIG        = 0;
  localparam int unsigned SY_CS          = 1;
  localparam int unsigned SY_RDWR        = 2;
  localparam int unsigned SY_SCLK        = 3;
  localparam int unsigned SY_DIN         = 4;
  localparam int unsigned SY_CMP         = 5;

  typedef enum logic [0:0] {
    ADCC_IDLE = 1'b0,
    ADCC_CONV = 1'b1
  } adcc_state_e;

endpackage

// ===== adcc_sync.sv
/*
  two-flop synchronisers with edge pulses, one lane per pin.
  assumes every input is asynchronous to pclk; edges come out one
  pclk cycle wide, two edges after the pin moves.
*/
`timescale 1ns/1ps
module adcc_sync #(
  parameter int unsigned W = 6
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins
  input  wire logic [W-1:0] async_in,
  // synchronised view
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta_reg;
      logic sync_reg;
      logic last_reg;
      // first flop is read by the second only
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
          last_reg <= 1'b1;
        end else begin
          meta_reg <= async_in[i];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign level[i] = sync_reg;
      assign rise[i]  = sync_reg & ~last_reg;
      assign fall[i]  = ~sync_reg & last_reg;
    end
  endgenerate

endmodule

// ===== adcc_monitor.sv
/*
  concurrent checks on the converter control block's ports.
  assumes it is bound onto adcc_top, with one pclk domain.
*/
`timescale 1ns/1ps
module adcc_monitor
  import adcc_pkg::*;
(
  // clock, reset and apb
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // host pins and front end
  input wire logic       conversion_trigger_n,
  input wire logic       port_select_n,
  input wire logic       read_write_sel,
  input wire logic       serial_dout_oe,
  input wire logic       busy,
  input wire logic       over_temp_flag_n,
  input wire logic       hold_mode,
  input wire logic [2:0] channel_sel
);
  localparam int VOLT_LIM = 90;
  localparam int TEMP_LIM = 270;
  logic [8:0] busy_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // counts busy cycles; too long to unroll as a repetition
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      busy_cnt <= 9'h000;
    else
      busy_cnt <= busy ? busy_cnt + 9'h001 : 9'h000;
  end
  a_start_on_fall: assert property ($fell(conversion_trigger_n) && !busy |-> ##[2:4] busy)
    else $error("conversion did not start on trigger fall");
  a_hold_with_busy: assert property (hold_mode == busy)
    else $error("sampling stage not in hold exactly while busy");
  a_volt_time: assert property (busy && channel_sel != TEMP_CHAN |-> busy_cnt < VOLT_LIM)
    else $error("voltage conversion too long");
  a_temp_time: assert property (busy |-> busy_cnt < TEMP_LIM)
    else $error("temperature conversion too long");
  a_flag_cause: assert property ($fell(over_temp_flag_n) |-> $fell(busy) && channel_sel == TEMP_CHAN)
    else $error("flag fell without a temperature result");
  a_flag_release: assert property ($rose(read_write_sel) && !port_select_n |-> ##[2:4] over_temp_flag_n)
    else $error("flag not released by serial read");
  a_flag_sticky: assert property ($rose(over_temp_flag_n) |-> read_write_sel && !port_select_n)
    else $error("flag released without a read");
  a_oe_deselect: assert property (port_select_n [*4] |-> !serial_dout_oe)
    else $error("serial output driven while deselected");
  a_oe_write_dir: assert property (!read_write_sel [*4] |-> !serial_dout_oe)
    else $error("serial output driven in write direction");
  a_apb_answer: assert property ($rose(penable) && psel |=> pready)
    else $error("apb access not answered in two cycles");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule

bind adcc_top adcc_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr),
  .conversion_trigger_n(conversion_trigger_n), .port_select_n(port_select_n),
  .read_write_sel(read_write_sel), .serial_dout_oe(serial_dout_oe), .busy(busy),
  .over_temp_flag_n(over_temp_flag_n), .hold_mode(hold_mode), .channel_sel(channel_sel));

// ===== adcc_host_model.sv
/*
  host model: drives the trigger and the serial port pins.
  assumes tasks are called right after a pclk rising edge.
*/
`timescale 1ns/1ps
module adcc_host (
  // clock and design outputs
  input wire logic pclk,
  input wire logic busy,
  input wire logic serial_dout,
  // host pins
  output logic     conversion_trigger_n,
  output logic     port_select_n,
  output logic     read_write_sel,
  output logic     serial_clk,
  output logic     serial_din
);
  logic tx_on;
  logic tx_bit;
  initial begin
    tx_on = 1'b0;
    tx_bit = 1'b0;
    conversion_trigger_n = 1'b1;
    port_select_n = 1'b1;
    read_write_sel = 1'b0;
    serial_clk = 1'b1;
    serial_din = 1'b0;
  end
  // din toggles outside writes, so any stray capture shows up in the result
  always @(posedge pclk) serial_din <= tx_on ? tx_bit : ~serial_din;
  // fall starts; optionally held low to ask for power-down
  task automatic convert(input logic stay_low, output int cnt);
    int n;
    cnt = 0;
    conversion_trigger_n <= 1'b1;
    repeat (4) @(posedge pclk);
    conversion_trigger_n <= 1'b0;
    for (n = 0; n < 400 && (n < 6 || busy === 1'b1); n++) begin
      @(posedge pclk);
      if (busy === 1'b1) cnt++;
      if (n == 5 && !stay_low) conversion_trigger_n <= 1'b1;
    end
  endtask
  // select, read high, bits taken before each fall
  task automatic read_bits(input logic sel_n, output logic [9:0] bits);
    int i;
    port_select_n <= sel_n;
    repeat (2) @(posedge pclk);
    read_write_sel <= 1'b1;
    repeat (6) @(posedge pclk);
    for (i = 9; i >= 0; i--) begin
      bits[i] = serial_dout;
      serial_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    read_write_sel <= 1'b0;
    repeat (6) @(posedge pclk);
    port_select_n <= 1'b1;
  endtask
  // select, read/write low, data set while the clock is low
  task automatic write_bits(input logic [7:0] b);
    int i;
    port_select_n <= 1'b0;
    tx_on <= 1'b1;
    repeat (2) @(posedge pclk);
    for (i = 7; i >= 0; i--) begin
      tx_bit <= b[i];
      serial_clk <= 1'b0;
      repeat (4) @(posedge pclk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    tx_on <= 1'b0;
    port_select_n <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
endmodule

// ===== tb_top.sv
/*
  self-checking bench for adcc_top with an apb master and host model.
  assumes a 10 MHz pclk; comparator modelled from an analog level.
*/
`timescale 1ns/1ps
module tb_top
  import adcc_pkg::*;
;
  localparam int VOLT = VOLT_CONV_NS / CLK_PERIOD_NS;
  localparam int TEMP = TEMP_CONV_NS / CLK_PERIOD_NS;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trig_n;
  logic        cs_n;
  logic        rd_wr;
  logic        sclk;
  logic        din;
  logic        dout;
  logic        dout_line;
  logic        dout_oe;
  logic        busy;
  logic        flag_n;
  logic        comp;
  logic [9:0]  dac;
  logic [2:0]  chan;
  logic        hold;
  logic        pdown;
  logic        irq;
  logic [9:0]  ain;
  logic [9:0]  bits;
  int          fails;
  int          compares;

  adcc_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conversion_trigger_n(trig_n), .port_select_n(cs_n),
    .read_write_sel(rd_wr), .serial_clk(sclk), .serial_din(din), .serial_dout(dout),
    .serial_dout_oe(dout_oe), .busy(busy), .over_temp_flag_n(flag_n),
    .comparator_above(comp), .dac_code(dac), .channel_sel(chan), .hold_mode(hold),
    .power_down(pdown), .irq(irq));
  // a released line reads as the inverse of the last bit, so a late sample shows
  assign dout_line = dout_oe ? dout : ~dout;
  adcc_host u_host (.pclk(pclk), .busy(busy), .serial_dout(dout_line),
    .conversion_trigger_n(trig_n), .port_select_n(cs_n), .read_write_sel(rd_wr),
    .serial_clk(sclk), .serial_din(din));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) comp <= (ain >= dac);

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic conv(input logic [2:0] ch, input logic [9:0] v, input logic low, input int lim);
    int cnt;
    wr(CTRL_OFS, 32'(ch));
    ain <= v;
    u_host.convert(low, cnt);
    chk(32'(cnt <= lim && cnt >= lim - 3), 32'h1);
    rd(RESULT_OFS, 32'(v));
    chk(32'({hold, chan, dac}), 32'({1'b0, ch, v}));
    chk(32'(pdown), 32'(low));
  endtask
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    chk(32'({flag_n, dout, irq, pdown, busy, hold, dout_oe, chan, dac}), 32'h0008_0000);
    rd(THRESH_OFS, 32'h000000ff);
    rd(CTRL_OFS, 32'h0);
    rd(IRQ_MASK_OFS, 32'h0);
    rd(STATE_OFS, 32'h00000002);
    apb(1'b0, 8'h1c, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
  endtask
  task automatic t_volt_irq();
    conv(3'h1, 10'h155, 1'b0, VOLT);
    chk(32'(irq), 32'h0);
    wr(IRQ_MASK_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1);
    rd(IRQ_STAT_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0);
  endtask
  task automatic t_temp();
    wr(THRESH_OFS, 32'h80);
    conv(TEMP_CHAN, 10'h203, 1'b1, TEMP);
    chk(32'(flag_n), 32'h1);
    conv(TEMP_CHAN, 10'h204, 1'b0, TEMP);
    chk(32'(flag_n), 32'h0);
    conv(3'h2, 10'h000, 1'b0, VOLT);
    conv(TEMP_CHAN, 10'h0a5, 1'b0, TEMP);
    chk(32'(flag_n), 32'h0);
  endtask
  task automatic t_serial();
    u_host.read_bits(1'b1, bits);
    chk(32'(flag_n), 32'h0);
    rd(IRQ_STAT_OFS, 32'h3);
    u_host.read_bits(1'b0, bits);
    chk(32'(bits), 32'h0a5);
    chk(32'(flag_n), 32'h1);
    chk(32'(dout_oe), 32'h0);
    rd(IRQ_STAT_OFS, 32'h4);
    u_host.write_bits(8'hc3);
    rd(SER_RX_OFS, 32'hc3);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ain = 10'h000;
    comp = 1'b0;
    fails = 0;
    compares = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_volt_irq();
    t_temp();
    t_serial();
    print_verdict();
  end
  // the sequence needs well under 1 ms of simulated time
  initial begin
    #3000000;
    fails++;
    print_verdict();
  end
endmodule
